// *** rtl/dst_xlate.sv ***
// Module: direct-store translation path and invalidate synchronisation
// ==========================================
`timescale 1ns/100ps
module dst_xlate
  import dst_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Access request from load/store unit (one per bus transaction)
  input wire logic req_valid,
  input wire dst_op_e req_op,
  input wire logic [31:0] effective_address_bits,
  input wire logic [31:0] segment_register,
  input wire logic block_translation_hit,
  input wire logic privilege_state_bit,
  input wire logic data_relocate_bit,
  input wire logic rc_changed,
  // Bus side
  input wire logic bus_ack,
  input wire logic inval_busy,
  input wire logic remote_sync_done,
  input wire logic snoop_tlbsync,
  input wire logic snoop_pending,
  // Results
  output logic req_ready,
  output logic page_walk,
  output logic [3:0] memory_attribute_bits,
  output logic pkt_valid,
  output logic pkt_addr_only,
  output logic [31:0] pkt_data,
  output logic fault,
  output logic [31:0] data_fault_status_reg,
  output logic noop_done,
  output logic stall,
  output logic rc_byte_we,
  output logic [7:0] rc_byte,
  output logic address_retry_response
);
  // ==========================================
  // State
  typedef struct packed {
    dst_state_e st;
    logic [31:0] pkt1;
    logic ready;
    logic walk;
    logic [3:0] attr;
    logic pv;
    logic [31:0] pd;
    logic flt;
    logic [31:0] fsr;
    logic nop;
    logic stl;
    logic rcwe;
    logic [7:0] rcb;
    logic retry;
  } dst_s;
  dst_s cur_ff, nxt_ff;

  // Packet builder link
  dst_pkt_if pk ();
  assign pk.seg = segment_register;
  assign pk.ea = effective_address_bits;
  assign pk.priv = privilege_state_bit;
  dst_pkt_build u_build (
    .pk(pk)
  );

  // Decode of a direct-store hit
  function automatic logic is_direct(input logic [31:0] seg,
    input logic bh);
    is_direct = seg[DST_SEG_T_POS] && !bh;
  endfunction

  logic direct;
  assign direct = is_direct(segment_register, block_translation_hit);

  // ==========================================
  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.pv = 1'b0;
    nxt_ff.flt = 1'b0;
    nxt_ff.nop = 1'b0;
    nxt_ff.rcwe = 1'b0;
    nxt_ff.walk = 1'b0;
    nxt_ff.stl = 1'b0;
    // Retry lasts while snooped sync sees pending work
    nxt_ff.retry = snoop_tlbsync && snoop_pending;
    unique case (cur_ff.st)
      DST_IDLE: begin
        nxt_ff.ready = 1'b1;
        if (req_valid && cur_ff.ready) begin
          unique case (req_op)
            DST_OP_RESV: begin
              // Fault when direct-store or relocation off
              if (direct || !data_relocate_bit) begin
                nxt_ff.flt = 1'b1;
                nxt_ff.fsr = 32'h0;
                nxt_ff.fsr[DST_FAULT_POS] = 1'b1;
              end else begin
                nxt_ff.walk = 1'b1;
              end
            end
            DST_OP_CACHE: begin
              if (direct) begin
                nxt_ff.nop = 1'b1;
              end else begin
                nxt_ff.walk = 1'b1;
              end
            end
            DST_OP_SYNC: begin
              // Hold the core while local invalidate runs
              nxt_ff.stl = inval_busy;
              nxt_ff.ready = !inval_busy;
            end
            DST_OP_TLBSYNC: begin
              // Completion only once remote processors finish
              nxt_ff.stl = !remote_sync_done;
              nxt_ff.ready = remote_sync_done;
            end
            DST_OP_RCUPD: begin
              // Byte-wide write leaves other entry bytes alone
              nxt_ff.rcwe = !direct;
              nxt_ff.rcb = {6'h0, 1'b1, rc_changed};
            end
            default: begin
              if (direct) begin
                // Each transaction starts its own packet pair
                nxt_ff.attr = DST_ATTR_DIRECT;
                nxt_ff.pd = pk.pkt0;
                nxt_ff.pkt1 = pk.pkt1;
                nxt_ff.pv = 1'b1;
                nxt_ff.ready = 1'b0;
                nxt_ff.st = DST_PKT0;
              end else begin
                nxt_ff.walk = 1'b1;
              end
            end
          endcase
        end
      end
      DST_PKT0: begin
        nxt_ff.pv = !bus_ack;
        if (bus_ack) begin
          nxt_ff.pd = cur_ff.pkt1;
          nxt_ff.pv = 1'b1;
          nxt_ff.st = DST_PKT1;
        end
      end
      DST_PKT1: begin
        nxt_ff.pv = !bus_ack;
        if (bus_ack) begin
          nxt_ff.ready = 1'b1;
          nxt_ff.st = DST_IDLE;
        end
      end
      default: nxt_ff.st = DST_IDLE;
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: DST_IDLE, pkt1: DST_PKT_RST, ready: 1'b0,
        walk: 1'b0, attr: 4'h0, pv: 1'b0, pd: DST_PKT_RST, flt: 1'b0,
        fsr: 32'h0, nop: 1'b0, stl: 1'b0, rcwe: 1'b0, rcb: 8'h0,
        retry: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from the state register
  assign req_ready = cur_ff.ready;
  assign page_walk = cur_ff.walk;
  assign memory_attribute_bits = cur_ff.attr;
  assign pkt_valid = cur_ff.pv;
  assign pkt_addr_only = cur_ff.pv;
  assign pkt_data = cur_ff.pd;
  assign fault = cur_ff.flt;
  assign data_fault_status_reg = cur_ff.fsr;
  assign noop_done = cur_ff.nop;
  assign stall = cur_ff.stl;
  assign rc_byte_we = cur_ff.rcwe;
  assign rc_byte = cur_ff.rcb;
  assign address_retry_response = cur_ff.retry;

  // ==========================================
  // Checks
  // Key the first packet should carry, rebuilt from the raw inputs
  logic key_exp;
  assign key_exp = privilege_state_bit ? segment_register[DST_SEG_KP_POS] :
    segment_register[DST_SEG_KS_POS];
  attr_forced_a: assert property (@(posedge mclk) disable iff (rst)
    pkt_valid |-> memory_attribute_bits == 4'h5)
    else $error("direct access without forced attributes");
  pkt_pair_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.st == DST_PKT0 && bus_ack) |=> cur_ff.st == DST_PKT1)
    else $error("second packet missing");
  no_walk_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && direct && req_op == DST_OP_LDST)
    |=> !page_walk && pkt_valid)
    else $error("direct access walked tables");
  fault_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && req_op == DST_OP_RESV && direct)
    |=> fault && data_fault_status_reg[26])
    else $error("reserve op not faulted");
  cache_noop_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && req_op == DST_OP_CACHE && direct)
    |=> noop_done && !page_walk)
    else $error("cache op not a no-op");
  sync_stall_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && req_op == DST_OP_SYNC && inval_busy)
    |=> stall)
    else $error("sync did not stall");
  tsync_wait_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && req_op == DST_OP_TLBSYNC &&
    !remote_sync_done) |=> stall && !req_ready)
    else $error("invalidate sync finished early");
  retry_resp_a: assert property (@(posedge mclk) disable iff (rst)
    (snoop_tlbsync && snoop_pending) |=> address_retry_response)
    else $error("retry not asserted");
  key_sel_a: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && req_ready && direct && req_op == DST_OP_LDST)
    |=> pkt_data[29] == $past(key_exp))
    else $error("wrong key in first packet");
endmodule

// *** rtl/dst_pkg.sv ***
// Package: constants and types for the direct-store translation block
package dst_pkg;
  // ==========================================
  // Widths
  localparam int DST_AW = 32;
  // ==========================================
  // Forced memory attributes: uncached, non-coherent, guarded
  localparam logic [3:0] DST_ATTR_DIRECT = 4'h5;
  // Segment register field positions (bit 0 is the msb)
  localparam int DST_SEG_T_POS = 31;   // Direct-store select (bit 0)
  localparam int DST_SEG_KS_POS = 30;  // Supervisor key (bit 1)
  localparam int DST_SEG_KP_POS = 29;  // User key (bit 2)
  localparam int DST_PKT0_LSB = 0;     // Bits 3..31 of segment register
  localparam int DST_PKT0_W = 29;
  localparam int DST_EA_LOW_W = 28;    // Effective address bits 4..31
  localparam int DST_SEG_LOW_W = 4;    // Segment register bits 28..31
  // Fault status bit position 5 from the msb
  localparam int DST_FAULT_POS = 26;
  // Reset value of the packet bus
  localparam logic [31:0] DST_PKT_RST = 32'h0;
  // ==========================================
  // Operation classes presented with each access
  typedef enum logic [2:0] {
    DST_OP_LDST,     // Plain load or store
    DST_OP_RESV,     // Reserve or conditional or external control word
    DST_OP_CACHE,    // Cache management operation
    DST_OP_SYNC,     // Synchronise
    DST_OP_TLBSYNC,  // Invalidate synchronise
    DST_OP_RCUPD     // Referenced / changed update
  } dst_op_e;
  // Sequencer states
  typedef enum logic [1:0] {
    DST_IDLE,
    DST_PKT0,
    DST_PKT1
  } dst_state_e;
endpackage

// *** rtl/dst_pkt_if.sv ***
// Interface: packet carrier between sequencer and packet builder
`timescale 1ns/100ps
interface dst_pkt_if;
  import dst_pkg::*;
  logic [31:0] seg;   // Segment register contents
  logic [31:0] ea;    // Effective address
  logic priv;         // Privilege state bit
  logic [31:0] pkt0;  // Built first packet
  logic [31:0] pkt1;  // Built second packet
  modport build (input seg, input ea, input priv, output pkt0, output pkt1);
  modport use_pkt (output seg, output ea, output priv, input pkt0,
    input pkt1);
endinterface

// *** rtl/dst_pkt_build.sv ***
// Module: builds the two address-only packet words of a direct-store access
`timescale 1ns/100ps
module dst_pkt_build
  import dst_pkg::*;
(
  // Packet carrier
  dst_pkt_if.build pk
);
  // ==========================================
  // Packet assembly
  // Key selection by privilege; the other key is dropped
  logic key;
  always_comb begin
    key = pk.priv ? pk.seg[DST_SEG_KP_POS] : pk.seg[DST_SEG_KS_POS];
    // No protection check here; the controller enforces it
    pk.pkt0 = {2'h0, key, pk.seg[DST_PKT0_W-1:0]};
    pk.pkt1 = {pk.seg[DST_SEG_LOW_W-1:0],
      pk.ea[DST_EA_LOW_W-1:0]};
  end
endmodule

// *** sim/dst_mem_ctrl.sv ***
// Behavioural memory controller that accepts direct-store packets
`timescale 1ns/100ps
module dst_mem_ctrl
  import dst_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Packet side
  input wire logic pkt_valid,
  input wire logic pkt_addr_only,
  // Answer pacing, 0 answers promptly
  input wire logic [3:0] delay,
  output logic bus_ack
);
  // ==========================================
  // Acceptance
  logic [3:0] wait_ff; // Cycles waited on the current packet
  // Key is taken as given; any protection is this side's business
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      wait_ff <= 4'h0;
    end else if (pkt_valid && pkt_addr_only && !bus_ack) begin
      // A data-carrying packet is never acked, so it hangs visibly
      if (wait_ff >= delay) begin
        bus_ack <= 1'b1;
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      bus_ack <= 1'b0;
    end
  end
endmodule

// *** sim/direct_store_translation_tb.sv ***
// Self-checking bench for the direct-store translation block
`timescale 1ns/100ps
module direct_store_translation_tb;
  import dst_pkg::*;
  // ==========================================
  // Signals
  logic mclk = 0, rst = 1, req_valid = 0, block_translation_hit = 0;
  logic privilege_state_bit = 0, data_relocate_bit = 1, rc_changed = 0;
  logic inval_busy = 0, remote_sync_done = 1, snoop_tlbsync = 0;
  logic snoop_pending = 0, bus_ack, busy_seen;
  dst_op_e req_op = DST_OP_LDST;
  logic [31:0] effective_address_bits = 0, segment_register = 0;
  logic req_ready, page_walk, pkt_valid, pkt_addr_only, fault, noop_done;
  logic stall, rc_byte_we, address_retry_response;
  logic [3:0] memory_attribute_bits, delay = 0;
  logic [31:0] pkt_data, data_fault_status_reg;
  logic [7:0] rc_byte;
  logic [35:0] note_q[$]; // Expected results, kind over value
  int bad_count = 0, tests_run = 0, stall_cnt = 0;
  always #2 mclk = ~mclk;
  dst_xlate u_dut (.mclk, .rst, .req_valid, .req_op,
    .effective_address_bits, .segment_register, .block_translation_hit,
    .privilege_state_bit, .data_relocate_bit, .rc_changed, .bus_ack,
    .inval_busy, .remote_sync_done, .snoop_tlbsync, .snoop_pending,
    .req_ready, .page_walk, .memory_attribute_bits, .pkt_valid,
    .pkt_addr_only, .pkt_data, .fault, .data_fault_status_reg, .noop_done,
    .stall, .rc_byte_we, .rc_byte, .address_retry_response);
  dst_mem_ctrl u_mc (.mclk, .rst, .pkt_valid, .pkt_addr_only, .delay,
    .bus_ack);
  // ==========================================
  // Checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    chk("notes left", note_q.size(), 0);
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Unexpected result shows up as a kind mismatch against all ones
  task automatic take(input logic [3:0] k, input logic [31:0] v);
    logic [35:0] n;
    n = (note_q.size() > 0) ? note_q.pop_front() : 36'hf_ffff_ffff;
    chk("result kind", k, n[35:32]);
    chk("result value", v, n[31:0]);
  endtask
  // ==========================================
  // Output monitor, samples the registered outputs at each rising edge
  always @(posedge mclk) begin
    if (rst === 1'b0) begin
      if ((pkt_valid & bus_ack) === 1'b1) begin
        take(4'h1, pkt_data);
        chk("attributes", memory_attribute_bits, DST_ATTR_DIRECT);
        chk("address only", pkt_addr_only, 1'b1);
      end
      if (fault === 1'b1) take(4'h2, data_fault_status_reg);
      if (noop_done === 1'b1) take(4'h3, 32'h0);
      if (page_walk === 1'b1) take(4'h4, 32'h0);
      if (rc_byte_we === 1'b1) take(4'h5, rc_byte);
      if (stall === 1'b1) stall_cnt++;
    end
  end
  // ==========================================
  // Request driver, holds the request until it is taken
  task automatic req(input dst_op_e op, input logic [31:0] s, e,
                     input logic pr, dr, bh, ch);
    int n;
    logic again;
    n = 0;
    again = 1'b1;
    req_valid <= 1'b1;
    req_op <= op;
    segment_register <= s;
    effective_address_bits <= e;
    privilege_state_bit <= pr;
    data_relocate_bit <= dr;
    block_translation_hit <= bh;
    rc_changed <= ch;
    // Sync kinds are offered again while the design answers with a stall
    while (again && n < 300) begin
      do begin
        @(negedge mclk);
        n++;
      end while (req_ready !== 1'b1 && n < 300);
      busy_seen = inval_busy | ~remote_sync_done;
      @(posedge mclk);
      again = 1'b0;
      if (op == DST_OP_SYNC || op == DST_OP_TLBSYNC) begin
        @(negedge mclk);
        n++;
        again = (stall === 1'b1);
      end
    end
    // Back on a rising edge; a repeated completed sync is harmless
    if (op == DST_OP_SYNC || op == DST_OP_TLBSYNC) @(posedge mclk);
    if (n >= 300) begin
      bad_count++;
      final_report();
    end
  endtask
  // Direct-store load or store, notes both packets
  task automatic ds(input logic [31:0] s, e, input logic pr);
    note_q.push_back({4'h1, 2'b00, pr ? s[29] : s[30], s[28:0]});
    note_q.push_back({4'h1, s[3:0], e[27:0]});
    req(DST_OP_LDST, s, e, pr, 1'b1, 1'b0, 1'b0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(77));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // Back-to-back direct-store accesses, prompt and slow controller
    for (int i = 0; i < 8; i++) begin
      delay <= i[0] ? 4'h3 : 4'h0;
      ds($urandom | 32'h8000_0000, $urandom, i[1]);
    end
    // Block hit wins over direct-store select
    note_q.push_back({4'h4, 32'h0});
    req(DST_OP_LDST, 32'hffff_ffff, $urandom, 0, 1, 1, 0);
    // Ordinary segment takes the page path
    note_q.push_back({4'h4, 32'h0});
    req(DST_OP_LDST, 32'h7fff_ffff, $urandom, 0, 1, 0, 0);
    // Reserve class faults on direct-store and with relocation off
    note_q.push_back({4'h2, 32'h1 << DST_FAULT_POS});
    req(DST_OP_RESV, 32'h8000_0000, $urandom, 1, 1, 0, 0);
    note_q.push_back({4'h2, 32'h1 << DST_FAULT_POS});
    req(DST_OP_RESV, 32'h0, $urandom, 0, 0, 0, 0);
    // Cache operation on direct-store completes with no effect
    note_q.push_back({4'h3, 32'h0});
    req(DST_OP_CACHE, 32'h8000_0000, $urandom, 0, 1, 0, 0);
    // Byte store of ref/changed, none for a direct-store segment
    note_q.push_back({4'h5, 32'h3});
    req(DST_OP_RCUPD, 32'h0, $urandom, 0, 1, 1, 1);
    req(DST_OP_RCUPD, 32'h8000_0000, $urandom, 0, 1, 0, 1);
    // Sync held off while the local invalidate runs
    inval_busy <= 1'b1;
    fork
      req(DST_OP_SYNC, 32'h0, 32'h0, 0, 1, 0, 0);
      begin
        repeat (6) @(posedge mclk);
        inval_busy <= 1'b0;
      end
    join
    chk("sync taken early", busy_seen, 1'b0);
    chk("stall seen", stall_cnt > 0, 1'b1);
    // Invalidate sync held off until remote processors finish
    remote_sync_done <= 1'b0;
    fork
      req(DST_OP_TLBSYNC, 32'h0, 32'h0, 0, 1, 0, 0);
      begin
        repeat (6) @(posedge mclk);
        remote_sync_done <= 1'b1;
      end
    join
    chk("tlbsync taken early", busy_seen, 1'b0);
    req_valid <= 1'b0;
    // Snooped invalidate sync retried only while work is pending
    snoop_tlbsync <= 1'b1;
    snoop_pending <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("retry asserted", address_retry_response, 1'b1);
    @(posedge mclk);
    snoop_pending <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("retry dropped", address_retry_response, 1'b0);
    repeat (10) @(posedge mclk);
    final_report();
  end
endmodule
